// ===== manchester_config_link_bench.sv
// Testbench: commands, store verify, calibration and readback of the link
`timescale 1ns/1ps
`default_nettype none

module manchester_config_link_bench;
  import mcl_pkg::*;
  logic clk; // System clock
  logic rstn; // Reset, active low
  logic detectIn; // Comparator stimulus
  logic storeAccept; // Store acknowledges writes
  logic calDone; // Ramp end pulse
  logic calPass; // Ramp reached reference
  logic [9:0] ledCountIn; // DRIVE_CURRENT_COUNT count at ramp end
  logic [1:0] gainCountIn; // Gain count at ramp end
  mcl_pin_s calPin; // Cal pin drive
  mcl_pin_s outPin; // Output pin drive
  logic calStart; // Ramp start pulse
  logic errorFlag; // Verify error
  logic [3:0] thresholdSel; // Threshold code
  logic hostLvl; // Host drive on cal pin
  logic calLine; // Resolved cal pin
  logic outLine; // Resolved output pin
  logic [36:0] frame; // Received readback
  logic frameOk; // Readback timing good
  int bad_count = 0; // Mismatches
  int check_count = 0; // Comparisons

  // Device wins the cal pin while enabled; output pin has a pull-up
  assign calLine = calPin.oeN ? hostLvl : calPin.level;
  assign outLine = outPin.oeN ? 1'b1 : outPin.level;

  // Short ramp and status windows keep the run brief
  mcl_config_link #(.RAMP_CYC(200), .STATUS_CYC(100)) u_dut (
    .clk(clk),
    .rstn(rstn),
    .calPinIn(calLine),
    .calPin(calPin),
    .detectIn(detectIn),
    .outPin(outPin),
    .storeAccept(storeAccept),
    .calStart(calStart),
    .calDone(calDone),
    .calPass(calPass),
    .ledCountIn(ledCountIn),
    .gainCountIn(gainCountIn),
    .thresholdSel(thresholdSel),
    .errorFlag(errorFlag)
  );

  mcl_host_model u_host (
    .clk(clk),
    .pinLvl(outLine),
    .lineLvl(hostLvl)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compares and counts, reporting any difference
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sends a command and waits out decode and verify
  task automatic cmd(input logic [11:0] bits, input int n, input int half);
    u_host.send(bits, n, half);
    // Frame ends three half bits after the last mid-bit, verify follows
    repeat (2 * half + 40) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    int n;
    rstn = 1'b0;
    detectIn = 1'b0;
    storeAccept = 1'b1;
    calDone = 1'b0;
    calPass = 1'b0;
    ledCountIn = 10'h000;
    gainCountIn = 2'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    check(thresholdSel, 4'h0);
    check(errorFlag, 1'b0);
    check(calPin, 2'b01);
    // Reset setting is inverted push-pull: no object drives high
    check(outPin, 2'b10);
    // A lost store must be caught by the read back
    storeAccept <= 1'b0;
    cmd(12'hC8B, 12, 500);
    check(errorFlag, 1'b1);
    check(thresholdSel, 4'h0);
    // Same write at the fastest rate, stored this time
    storeAccept <= 1'b1;
    cmd(12'hC8B, 12, 500);
    check(errorFlag, 1'b0);
    check(thresholdSel, 4'hB);
    // Buffered open drain: low is driven, high releases the pin
    check(outPin, 2'b00);
    detectIn <= 1'b1;
    repeat (10) @(posedge clk);
    check(outPin, 2'b01);
    detectIn <= 1'b0;
    // Wrong sync must leave the bank alone
    cmd(12'hD80, 12, 500);
    check(thresholdSel, 4'hB);
    // Calibration at the nominal rate
    u_host.send(12'h033, 6, 1000);
    n = 0;
    while (calStart !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    // Start pulse never came
    if (n >= 5000) begin
      bad_count++;
      final_report();
    end
    repeat (5) @(posedge clk);
    check(calPin, 2'b10);
    calDone <= 1'b1;
    calPass <= 1'b1;
    ledCountIn <= 10'h03B;
    gainCountIn <= 2'h1;
    @(posedge clk);
    calDone <= 1'b0;
    repeat (10) @(posedge clk);
    check(calPin, 2'b00);
    repeat (120) @(posedge clk);
    check(calPin.oeN, 1'b1);
    // Readback after success carries the new counts
    u_host.send(12'h031, 6, 500);
    u_host.recv(frame, frameOk);
    check(frameOk, 1'b1);
    check(frame, {7'h00, 1'b0, 1'b0, 4'hB, 10'h03B, 2'h1, 1'b1, 9'h000, 2'h0});
    final_report();
  end

  // Watchdog against a hang
  initial begin
    repeat (150000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule

`default_nettype wire

// ===== mcl_config_link.sv
// Command receiver, bank store with verify, calibration and readback sender
//
// Functional notes
// - Write command is exactly twelve bits
// - Commands accepted from 50 to 200 kb/s
// - Readback Manchester at 100 kb/s, even halves
// - 37-bit frame, zero start, error second
// - Reserved, calibration, gain, drive count, LSB first
// - Threshold LSB first, then driver, polarity
// - Frame bits 31 to 37 zero
// - Write read back, mismatch sets error
// - Cal pin takes commands, reports status
// - Polarity inverts, driver selects push-pull
// - Threshold code picks sixteen rising levels
// - Six data bits map to bank fields
// - Manchester: rise is one, fall zero
// - Sync 1100 then two command bits
// - Pin high during ramp, low on success
`timescale 1ns/1ps
`default_nettype none
`include "mcl_defs.svh"

module mcl_config_link #(
  parameter int RAMP_CYC = `MCL_RAMP_CYC, // Longest calibration ramp
  parameter int STATUS_CYC = `MCL_STATUS_CYC // Status report window
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic calPinIn, // Calibrate/status pin, input side
  output mcl_pkg::mcl_pin_s calPin, // Calibrate/status pin drive
  input wire logic detectIn, // Raw comparator result
  output mcl_pkg::mcl_pin_s outPin, // Logic output pin drive
  input wire logic storeAccept, // Store takes the write this cycle
  output logic calStart, // Pulse: begin DRIVE_CURRENT_COUNT ramp
  input wire logic calDone, // Pulse: ramp finished
  input wire logic calPass, // Ramp reached reference
  input wire logic [9:0] ledCountIn, // DRIVE_CURRENT_COUNT count at end of ramp
  input wire logic [1:0] gainCountIn, // Gain count at end of ramp
  output logic [3:0] thresholdSel, // Comparator reference code
  output logic errorFlag // Write verify failed
);
  import mcl_pkg::*;

  // Verify helper: any difference between stored and written
  function automatic logic differs(input logic [18:0] got, input logic [18:0] want);
    differs = got != want;
  endfunction

  // Drive helper: open drain releases the line for a high
  function automatic mcl_pin_s driveOf(input logic lvl, input logic pushPull);
    mcl_pin_s p;
    p.level = pushPull ? lvl : 1'b0;
    p.oeN = pushPull ? 1'b0 : lvl;
    driveOf = p;
  endfunction

  logic [1:0] rawIn; // Asynchronous pins
  logic [1:0] syncLvl; // Filtered pin levels
  logic calLvl; // Filtered cal pin
  logic detLvl; // Filtered comparator
  mcl_rxev_s rxEv; // Decoder events
  mcl_state_e state_q; // Main sequencer
  logic [11:0] rxShift_q; // Received bits, newest at bit 0
  logic [3:0] rxCount_q; // Bits in this command
  mcl_cfg_s cfg_q; // Output configuration bank
  mcl_cal_s cal_q; // Calibration result bank
  logic [8:0] rsvd_q; // Reserved bank
  mcl_cfg_s wrCfg_q; // Configuration being written
  mcl_cal_s wrCal_q; // Calibration result being written
  logic calCtx_q; // Store belongs to a calibration
  logic err_q; // Error flag
  logic [21:0] tick_q; // Ramp, status and half-bit timer
  logic [5:0] bitIdx_q; // Frame bit being sent
  logic phase_q; // Second half of bit
  logic [36:0] frame_q; // Latched readback frame
  mcl_pin_s calPin_q; // Registered cal pin drive
  mcl_pin_s outPin_q; // Registered out pin drive
  logic calStart_q; // Ramp start pulse
  logic txBit; // Bit on the wire
  logic txLvl; // Encoded level
  logic shortOk; // Six-bit command with good sync
  logic longOk; // Twelve-bit command with good sync
  mcl_cmd_e cmdShort; // Command of a six-bit frame

  assign rawIn = {detectIn, calPinIn};
  // Three flops per pin; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gSync
      logic [2:0] s_q;
      logic lvl_q;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s_q <= 3'h0;
          lvl_q <= 1'b0;
        end else begin
          s_q <= {s_q[1:0], rawIn[g]};
          if (s_q[1] == s_q[2]) begin
            lvl_q <= s_q[2];
          end
        end
      end
      assign syncLvl[g] = lvl_q;
    end
  endgenerate
  assign calLvl = syncLvl[0];
  assign detLvl = syncLvl[1];

  // Decoder listens only while the pin is an input
  mcl_manchester_rx uRx (
    .clk(clk),
    .rstn(rstn),
    .enable(state_q == ST_LISTEN),
    .lineLvl(calLvl),
    .rxEv(rxEv)
  );

  assign shortOk = rxCount_q == `MCL_LEN_SHORT && rxShift_q[5:2] == `MCL_SYNC;
  assign longOk = rxCount_q == `MCL_LEN_WRITE && rxShift_q[11:8] == `MCL_SYNC;
  assign cmdShort = mcl_cmd_e'(rxShift_q[1:0]);

  // Shift register; counts saturate so long garbage never matches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShift_q <= 12'h000;
      rxCount_q <= 4'h0;
    end else if (rxEv.frameEnd || rxEv.abort || state_q != ST_LISTEN) begin
      rxCount_q <= 4'h0;
    end else if (rxEv.bitValid) begin
      rxShift_q <= {rxShift_q[10:0], rxEv.bitVal};
      if (rxCount_q != `MCL_LEN_OVER) begin
        rxCount_q <= 4'(rxCount_q + 4'h1);
      end
    end
  end

  // Main sequencer and timers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_LISTEN;
      tick_q <= 22'h000000;
      bitIdx_q <= 6'h00;
      phase_q <= 1'b0;
      calCtx_q <= 1'b0;
      calStart_q <= 1'b0;
      wrCfg_q <= `MCL_CFG_RESET;
      wrCal_q <= `MCL_CAL_RESET;
      frame_q <= '0;
    end else begin
      calStart_q <= 1'b0;
      unique case (state_q)
        ST_LISTEN: begin
          tick_q <= 22'h000000;
          if (rxEv.frameEnd) begin
            if (longOk && rxShift_q[7:6] == 2'(CMD_WRITE)) begin
              // data arrives five down to zero
              wrCfg_q <= rxShift_q[5:0];
              wrCal_q <= cal_q;
              calCtx_q <= 1'b0;
              state_q <= ST_STORE;
            end else if (shortOk && cmdShort == CMD_READ) begin
              // fields LSB first, index is send order
              frame_q <= {7'h00, cfg_q.outputPolarityBit, cfg_q.driverTypeBit,
                          cfg_q.thresholdSel, cal_q.driveCurrentCount,
                          cal_q.gainCountBits, cal_q.calibrationOkBit, rsvd_q,
                          err_q, 1'b0};
              bitIdx_q <= 6'h00;
              phase_q <= 1'b0;
              state_q <= ST_SEND;
            end else if (shortOk && cmdShort == CMD_CAL) begin
              calStart_q <= 1'b1;
              state_q <= ST_RAMP;
            end
          end
        end
        // ramp ends on done or at the limit
        ST_RAMP: begin
          tick_q <= 22'(tick_q + 22'h000001);
          if (calDone || tick_q == 22'(RAMP_CYC - 1)) begin
            wrCfg_q <= cfg_q;
            wrCal_q.calibrationOkBit <= calDone && calPass;
            wrCal_q.driveCurrentCount <= (calDone && calPass) ? ledCountIn : cal_q.driveCurrentCount;
            wrCal_q.gainCountBits <= (calDone && calPass) ? gainCountIn : cal_q.gainCountBits;
            calCtx_q <= 1'b1;
            state_q <= ST_STORE;
          end
        end
        ST_STORE: begin
          state_q <= ST_VERIFY;
        end
        ST_VERIFY: begin
          tick_q <= 22'h000000;
          state_q <= calCtx_q ? ST_STATUS : ST_LISTEN;
        end
        ST_STATUS: begin
          tick_q <= 22'(tick_q + 22'h000001);
          if (tick_q == 22'(STATUS_CYC - 1)) begin
            state_q <= ST_LISTEN;
          end
        end
        ST_SEND: begin
          if (tick_q == 22'(`MCL_TX_HALF_CYC - 1)) begin
            tick_q <= 22'h000000;
            phase_q <= !phase_q;
            if (phase_q) begin
              if (bitIdx_q == `MCL_FRAME_LAST) begin
                state_q <= ST_LISTEN;
              end else begin
                bitIdx_q <= 6'(bitIdx_q + 6'h01);
              end
            end
          end else begin
            tick_q <= 22'(tick_q + 22'h000001);
          end
        end
      endcase
    end
  end

  // Bank storage; a write the store refuses leaves old content
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= `MCL_CFG_RESET;
      cal_q <= `MCL_CAL_RESET;
      rsvd_q <= `MCL_RSVD_RESET;
    end else if (state_q == ST_STORE && storeAccept) begin
      cfg_q <= wrCfg_q;
      cal_q <= wrCal_q;
    end
  end

  // read back and compare after each write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else if (state_q == ST_VERIFY) begin
      err_q <= differs({cfg_q, cal_q}, {wrCfg_q, wrCal_q});
    end
  end

  assign txBit = frame_q[bitIdx_q];
  assign txLvl = phase_q ? txBit : !txBit;

  // cal pin: driven high in ramp and calibration store and verify, status level in status window, input otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calPin_q <= '{level: 1'b0, oeN: 1'b1};
    end else if (state_q == ST_STATUS) begin
      calPin_q <= driveOf(!cal_q.calibrationOkBit, 1'b1);
    end else if (state_q == ST_RAMP || calCtx_q && state_q != ST_LISTEN
                 && state_q != ST_SEND) begin
      calPin_q <= driveOf(1'b1, 1'b1);
    end else begin
      calPin_q <= '{level: 1'b0, oeN: 1'b1};
    end
  end

  // polarity and driver type on the logic output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outPin_q <= '{level: 1'b0, oeN: 1'b1};
    end else if (state_q == ST_SEND) begin
      outPin_q <= driveOf(txLvl, cfg_q.driverTypeBit);
    end else begin
      outPin_q <= driveOf(detLvl ^ cfg_q.outputPolarityBit, cfg_q.driverTypeBit);
    end
  end

  assign calPin = calPin_q;
  assign outPin = outPin_q;
  assign calStart = calStart_q;
  assign errorFlag = err_q;
  // code goes straight to the reference ladder
  assign thresholdSel = cfg_q.thresholdSel;

  // Checks
  AST_WRITE_LEN: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_LISTEN && rxEv.frameEnd && rxCount_q != `MCL_LEN_WRITE
    |=> state_q != ST_STORE) else $error("write taken from wrong length");
  AST_BAD_SYNC: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_LISTEN && rxEv.frameEnd && !shortOk && !longOk
    |=> state_q == ST_LISTEN ##1 $stable(cfg_q)) else $error("bad sync acted on");
  AST_WRITE_MAP: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_STORE && !calCtx_q && storeAccept
    |=> cfg_q == $past(rxShift_q[5:0], 2)) else $error("write data misplaced");
  AST_ERR_SET: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_STORE && !storeAccept && differs({cfg_q, cal_q}, {wrCfg_q, wrCal_q})
    |=> ##1 err_q) else $error("verify mismatch not flagged");
  AST_START_BIT: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_SEND && bitIdx_q == 6'h00 |-> txBit == 1'b0 && txLvl == !phase_q)
    else $error("start bit not zero");
  AST_TAIL_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_SEND && bitIdx_q >= `MCL_ZERO_FIRST |-> txBit == 1'b0)
    else $error("tail bit not zero");
  AST_HALF_BIT: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_SEND && $changed(phase_q) |-> $past(tick_q) == 22'(`MCL_TX_HALF_CYC - 1))
    else $error("half bit length wrong");
  AST_RAMP_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_RAMP ##1 state_q == ST_RAMP |-> calPin_q.level && !calPin_q.oeN)
    else $error("cal pin not high in ramp");
  AST_STATUS_LVL: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_STATUS ##1 state_q == ST_STATUS
    |-> calPin_q.level == !cal_q.calibrationOkBit) else $error("status level wrong");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rstn)
    state_q == ST_LISTEN ##1 state_q == ST_LISTEN
    |-> (cfg_q.driverTypeBit ? outPin_q == {$past(detLvl) ^ cfg_q.outputPolarityBit, 1'b0}
         : outPin_q == {1'b0, $past(detLvl) ^ cfg_q.outputPolarityBit}))
    else $error("output polarity or driver wrong");
  COV_WRITE: cover property (@(posedge clk) disable iff (!rstn) state_q == ST_STORE && !calCtx_q);
  COV_READ: cover property (@(posedge clk) disable iff (!rstn)
    state_q == ST_SEND && bitIdx_q == `MCL_FRAME_LAST);
  COV_CAL_OK: cover property (@(posedge clk) disable iff (!rstn)
    state_q == ST_STATUS && cal_q.calibrationOkBit);
  COV_OPEN_DRAIN: cover property (@(posedge clk) disable iff (!rstn)
    state_q == ST_SEND && !cfg_q.driverTypeBit);

endmodule
`default_nettype wire

// ===== mcl_defs.svh
// Constants for the single-wire configuration link: timing, framing, reset values
`ifndef MCL_DEFS_SVH
`define MCL_DEFS_SVH

// System clock rate in kHz (200 MHz, 5 ns period)
`define MCL_CLK_KHZ 200000

// Command framing
`define MCL_SYNC 4'hC
`define MCL_LEN_SHORT 4'd6
`define MCL_LEN_WRITE 4'd12
`define MCL_LEN_OVER 4'd13
`define MCL_FRAME_BITS 37
`define MCL_FRAME_LAST 6'd36
`define MCL_ZERO_FIRST 6'd30

// Readback rate: 100 kb/s, half bit in cycles
`define MCL_TX_KBPS 100
`define MCL_TX_HALF_CYC ((`MCL_CLK_KHZ / `MCL_TX_KBPS) / 2)

// Accepted command rates: 50 to 200 kb/s
`define MCL_RX_MIN_KBPS 50
`define MCL_RX_MAX_KBPS 200
`define MCL_RX_HALF_SLOW ((`MCL_CLK_KHZ / `MCL_RX_MIN_KBPS) / 2)
`define MCL_RX_HALF_FAST ((`MCL_CLK_KHZ / `MCL_RX_MAX_KBPS) / 2)
// Measured half bit must fall inside these, with 25 % slack
`define MCL_RX_HALF_LO ((`MCL_RX_HALF_FAST * 3) / 4)
`define MCL_RX_HALF_HI ((`MCL_RX_HALF_SLOW * 5) / 4)

// Calibration ramp and status windows, milliseconds and cycles
`define MCL_RAMP_MS 17
`define MCL_STATUS_MS 13
`define MCL_RAMP_CYC (`MCL_RAMP_MS * `MCL_CLK_KHZ)
`define MCL_STATUS_CYC (`MCL_STATUS_MS * `MCL_CLK_KHZ)

// Reset contents of the banks: inverted, push-pull, lowest threshold
`define MCL_CFG_RESET 6'h30
`define MCL_CAL_RESET 13'h0000
`define MCL_RSVD_RESET 9'h000

`endif

// ===== mcl_host_model.sv
// Host controller model: Manchester command sender and readback sampler
`timescale 1ns/1ps
`default_nettype none

module mcl_host_model (
  input wire logic clk, // System clock
  input wire logic pinLvl, // Resolved logic output pin level
  output logic lineLvl // Host drive onto the cal pin
);
  // Line idles low between commands
  initial begin
    lineLvl = 1'b0;
  end

  // Holds one level for a number of clock edges
  task automatic hold(input logic v, input int n);
    lineLvl <= v;
    repeat (n) @(posedge clk);
  endtask

  // n bits, first bit sent first, half bit in cycles
  task automatic send(input logic [11:0] bits, input int n, input int half);
    for (int i = n - 1; i >= 0; i--) begin
      // a one rises at mid-bit, a zero falls
      hold(~bits[i], half);
      hold(bits[i], half);
    end
    // Drop at once, or a late fall could read as an extra bit
    hold(1'b0, 1);
  endtask

  // finds the start bit's high half, then samples mid of each half bit
  task automatic recv(output logic [36:0] data, output logic ok);
    int w;
    logic a;
    data = '0;
    ok = 1'b0;
    w = 0;
    while (pinLvl !== 1'b1 && w < 30000) begin
      @(posedge clk);
      w++;
    end
    if (w < 30000) begin
      ok = 1'b1;
      // Drift over 37 bits exposes a wrong bit length
      for (int i = 0; i < 37; i++) begin
        repeat (500) @(posedge clk);
        a = pinLvl;
        repeat (1000) @(posedge clk);
        data[i] = pinLvl;
        // halves of a bit must differ
        ok = ok & (a === ~pinLvl);
        repeat (500) @(posedge clk);
      end
    end
  endtask
endmodule

`default_nettype wire

// ===== mcl_manchester_rx.sv
// Manchester decoder that learns the bit rate from the leading sync bits
`timescale 1ns/1ps
`default_nettype none
`include "mcl_defs.svh"

module mcl_manchester_rx (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic enable, // Low holds the decoder idle
  input wire logic lineLvl, // Filtered line level
  output mcl_pkg::mcl_rxev_s rxEv // Decoded events
);
  import mcl_pkg::*;

  mcl_rx_e state_q; // Decoder state
  logic prevLvl_q; // Line level one cycle ago
  logic [12:0] cnt_q; // Cycles since last mid-bit edge
  logic [12:0] half_q; // Learned half-bit length
  mcl_rxev_s rxEv_q; // Registered events
  logic edgeSeen; // Any line transition
  logic [12:0] winOpen; // Earliest next mid-bit edge
  logic [12:0] timeout; // Silence that ends a frame

  assign edgeSeen = lineLvl != prevLvl_q;
  // Boundary edges come at one half bit and are skipped
  assign winOpen = 13'(half_q + {1'b0, half_q[12:1]});
  assign timeout = 13'(half_q + {half_q[11:0], 1'b0});
  assign rxEv = rxEv_q;

  // Edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevLvl_q <= 1'b0;
    end else begin
      prevLvl_q <= lineLvl;
    end
  end

  // Rate learning and bit recovery
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RX_IDLE;
      cnt_q <= 13'h0000;
      half_q <= 13'h0000;
      rxEv_q <= '0;
    end else begin
      rxEv_q <= '0;
      if (!enable) begin
        state_q <= RX_IDLE;
        cnt_q <= 13'h0000;
      end else begin
        unique case (state_q)
          // Idle low: first rise is mid-bit of a leading one
          RX_IDLE: begin
            if (edgeSeen && lineLvl) begin
              rxEv_q.bitValid <= 1'b1;
              rxEv_q.bitVal <= 1'b1;
              cnt_q <= 13'h0000;
              state_q <= RX_MEASURE;
            end
          end
          RX_MEASURE: begin
            if (edgeSeen) begin
              if (cnt_q >= 13'(`MCL_RX_HALF_LO) && cnt_q <= 13'(`MCL_RX_HALF_HI)) begin
                half_q <= cnt_q;
                cnt_q <= 13'(cnt_q + 13'h0001);
                state_q <= RX_RUN;
              end else begin
                rxEv_q.abort <= 1'b1;
                state_q <= RX_IDLE;
              end
            end else if (cnt_q > 13'(`MCL_RX_HALF_HI)) begin
              rxEv_q.abort <= 1'b1;
              state_q <= RX_IDLE;
            end else begin
              cnt_q <= 13'(cnt_q + 13'h0001);
            end
          end
          // rising mid-bit is one, falling zero
          RX_RUN: begin
            if (edgeSeen && cnt_q >= winOpen) begin
              rxEv_q.bitValid <= 1'b1;
              rxEv_q.bitVal <= lineLvl;
              cnt_q <= 13'h0000;
            end else if (cnt_q >= timeout) begin
              rxEv_q.frameEnd <= 1'b1;
              state_q <= RX_IDLE;
            end else begin
              cnt_q <= 13'(cnt_q + 13'h0001);
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== mcl_pkg.sv
// Types shared by the configuration link modules
package mcl_pkg;

  // Output configuration bank, polarity in the top bit
  typedef struct packed {
    logic outputPolarityBit;
    logic driverTypeBit;
    logic [3:0] thresholdSel;
  } mcl_cfg_s;

  // Calibration result bank
  typedef struct packed {
    logic [9:0] driveCurrentCount;
    logic [1:0] gainCountBits;
    logic calibrationOkBit;
  } mcl_cal_s;

  // Pin drive: level and active-low enable
  typedef struct packed {
    logic level;
    logic oeN;
  } mcl_pin_s;

  // Decoder events, each a one-cycle pulse
  typedef struct packed {
    logic bitValid;
    logic bitVal;
    logic frameEnd;
    logic abort;
  } mcl_rxev_s;

  typedef enum logic [1:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_CAL} mcl_cmd_e;
  typedef enum {RX_IDLE, RX_MEASURE, RX_RUN} mcl_rx_e;
  typedef enum {ST_LISTEN, ST_STORE, ST_VERIFY, ST_RAMP, ST_STATUS, ST_SEND} mcl_state_e;

endpackage
